//--- hdl/grs_pkg.sv
// Purpose: shared constants and types of the gated replay sequencer
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: offsets, codes and reset values
package grs_pkg;

  // ==========================================================================
  // sizes
  localparam int AW = 16;
  localparam int DW = 32;
  localparam int SW = 16;
  localparam int NCH = 4;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [31:0] SAMPLE_BYTES = 32'h0000_0002;

  // ==========================================================================
  // register byte offsets
  localparam logic [AW-1:0] OFS_MODE = 16'h251C;
  localparam logic [AW-1:0] OFS_TOTAL = 16'h2710;
  localparam logic [AW-1:0] OFS_LOOPS = 16'h2724;
  localparam logic [AW-1:0] OFS_CTRL = 16'h3000;
  localparam logic [AW-1:0] OFS_IDLE = 16'h3004;
  localparam logic [AW-1:0] OFS_IGATE = 16'h3008;
  localparam logic [AW-1:0] OFS_MADDR = 16'h300C;
  localparam logic [AW-1:0] OFS_MDATA = 16'h3010;
  localparam logic [AW-1:0] OFS_STATUS = 16'h3014;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 16'h3018;
  localparam logic [AW-1:0] OFS_IRQ_CLR = 16'h301C;
  localparam logic [AW-1:0] OFS_IRQ_EN = 16'h3020;
  localparam logic [AW-1:0] OFS_COUNT = 16'h3024;

  // ==========================================================================
  // mode codes and loop values
  localparam logic [31:0] STANDARD_GATED_CODE = 32'h0000_0400;
  localparam logic [31:0] STREAMING_GATED_CODE = 32'h0000_2000;
  localparam logic [31:0] LOOPS_INFINITE = 32'h0000_0000;
  localparam logic [31:0] LOOPS_ONCE = 32'h0000_0001;

  // ==========================================================================
  // idle levels, 5-bit code per channel
  localparam int IDLE_W = 5;
  localparam logic [IDLE_W-1:0] IDLE_LEVEL_ZERO = 5'h10;
  localparam logic [IDLE_W-1:0] IDLE_LEVEL_NEGATIVE = 5'h02;
  localparam logic [IDLE_W-1:0] IDLE_LEVEL_POSITIVE = 5'h04;
  localparam logic [IDLE_W-1:0] IDLE_LEVEL_HOLD_PREVIOUS = 5'h08;
  localparam logic [SW-1:0] DAC_ZERO = 16'h0000;
  localparam logic [SW-1:0] DAC_MOST_NEG = 16'h8000;
  localparam logic [SW-1:0] DAC_MOST_POS = 16'h7FFF;

  // ==========================================================================
  // control and interrupt fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_GSRC_BIT = 4;
  localparam int CTRL_CH_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UNDERRUN = 1;
  localparam int IRQ_GATE = 2;
  localparam int NIRQ = 3;

  // ==========================================================================
  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] TOTAL_RST = 32'h0000_0008;
  localparam logic [31:0] LOOPS_RST = 32'h0000_0001;
  localparam logic [31:0] IGATE_RST = 32'h0008_0010;

  typedef enum logic [1:0] {
    GRS_IDLE = 2'b00,
    GRS_PAUSE = 2'b01,
    GRS_PLAY = 2'b11
  } grs_state_e;

endpackage

//--- hdl/grs_gate_sel.sv
// Purpose: picks the qualified gate from the external input or an internal generator
// Assumes: gate_ext_i already qualified by the trigger logic, synchronous to the clock
// Notes: gate_nx_o is the value gate_o takes at the next edge
module grs_gate_sel
  import grs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic gate_ext_i,
  input wire logic src_int_i,
  input wire logic run_i,
  input wire logic [15:0] period_i,
  input wire logic [15:0] width_i,
  output logic gate_nx_o,
  output logic gate_o
);

  logic [15:0] cnt;
  wire cnt_wrap = (cnt >= period_i - 16'h0001);
  wire [15:0] next_cnt = (!run_i || cnt_wrap) ? 16'h0000 : cnt + 16'h0001;
  wire int_gate = run_i && (cnt < width_i);

  assign gate_nx_o = src_int_i ? int_gate : gate_ext_i; // R17

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      gate_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      gate_o <= gate_nx_o;
    end
  end

endmodule // grs_gate_sel

//--- hdl/grs_idle_level.sv
// Purpose: per-channel level shown during pauses and after replay
// Assumes: last_i holds the last sample sent to each channel
// Notes: unknown codes fall back to zero level
module grs_idle_level
  import grs_pkg::*;
(
  input wire logic [NCH*IDLE_W-1:0] code_i,
  input wire logic [NCH*SW-1:0] last_i,
  output logic [NCH*SW-1:0] level_o
);

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire [IDLE_W-1:0] code = code_i[c*IDLE_W +: IDLE_W];
    assign level_o[c*SW +: SW] =
      (code == IDLE_LEVEL_NEGATIVE) ? DAC_MOST_NEG :
      (code == IDLE_LEVEL_POSITIVE) ? DAC_MOST_POS :
      (code == IDLE_LEVEL_HOLD_PREVIOUS) ? last_i[c*SW +: SW] : DAC_ZERO; // R16
  end

endmodule // grs_idle_level

//--- hdl/grs_top.sv
// Purpose: gated replay sequencer feeding four D/A channels
// Assumes: Avalon-MM register slave; gate and stream inputs synchronous to core_clk_i
// Notes: sample memory is a small flip-flop image written through a data port
//
// Behaviour
// R1 - samples go out only while the qualified gate is open; output halts at gate end
// R2 - between gates the sequencer pauses without advancing, then resumes
// R3 - standard mode, one loop: stop when sample total is reached, even mid-gate
// R4 - standard mode, zero loops: run until stopped, wrapping memory without a gap
// R5 - standard mode, loops two or more: play that many complete gates, then stop
// R6 - mode code 400h selects standard gated replay from memory
// R7 - sample total register holds samples replayed in standard mode; readable
// R8 - gate repeat count register holds gates to play; readable; meaning per mode
// R9 - mode code 2000h selects gated replay from the host stream
// R10 - stream mode, zero loops: run until stopped or an underrun ends it
// R11 - stream mode, loops one or more: play that many gates, then stop
// R12 - host keeps the stream fed so it never runs dry during replay
// R13 - each sample takes two bytes; memory addressing uses that size
// R14 - host programs sample total as a multiple of the step, at least the step
// R15 - host keeps sample total within memory share per active channel count
// R16 - idle channels show their configured level: zero, negative, positive, hold
// R17 - gate comes from the external input or the internal generator
// R18 - a new gate continues from the sample after the last one output
module grs_top
  import grs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic gate_ext_i,
  input wire logic [SW-1:0] stream_data_i,
  input wire logic stream_valid_i,
  output logic stream_ready_o,
  output logic [NCH*SW-1:0] dac_data_o,
  output logic running_o,
  output logic irq_o
);

  // ==========================================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================================
  // register state
  logic [31:0] mode_q;
  logic [31:0] total_q;
  logic [31:0] loops_q;
  logic gsrc_q;
  logic [1:0] ch_code_q;
  logic [NCH*IDLE_W-1:0] idle_q;
  logic [31:0] igate_q;
  logic [31:0] maddr_q;
  logic [SW-1:0] mem [MEM_DEPTH];
  logic [NIRQ-1:0] irq_stat_q;
  logic [NIRQ-1:0] irq_en_q;
  logic [31:0] out_cnt_q;
  logic [31:0] gates_q;
  grs_state_e state;
  grs_state_e next_state;
  logic std_q;
  logic [31:0] pos_q;
  logic [1:0] ch_idx_q;
  logic [NCH*SW-1:0] last_q;

  // ==========================================================================
  // bus decode
  wire acc = avs_read_i || avs_write_i;
  wire wr_go = avs_write_i && !avs_waitrequest_o;
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire wr_mode = wr_go && (avs_address_i == OFS_MODE);
  wire wr_total = wr_go && (avs_address_i == OFS_TOTAL);
  wire wr_loops = wr_go && (avs_address_i == OFS_LOOPS);
  wire wr_ctrl = wr_go && (avs_address_i == OFS_CTRL);
  wire wr_idle = wr_go && (avs_address_i == OFS_IDLE);
  wire wr_igate = wr_go && (avs_address_i == OFS_IGATE);
  wire wr_maddr = wr_go && (avs_address_i == OFS_MADDR);
  wire wr_mdata = wr_go && (avs_address_i == OFS_MDATA);
  wire wr_clr = wr_go && (avs_address_i == OFS_IRQ_CLR);
  wire wr_en = wr_go && (avs_address_i == OFS_IRQ_EN);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [31:0] wd_ctrl = avs_writedata_i & be_mask;
  wire sw_start = wr_ctrl && wd_ctrl[CTRL_START_BIT];
  wire sw_stop = wr_ctrl && wd_ctrl[CTRL_STOP_BIT];
  wire [31:0] ctrl_rd = {22'h00_0000, ch_code_q, 3'h0, gsrc_q, 4'h0};
  wire [31:0] status_rd = {gates_q[27:0], 1'b0, std_q, state};

  logic [31:0] rd_mux;
  always_comb begin
    if (avs_address_i == OFS_MODE) begin
      rd_mux = mode_q;
    end else if (avs_address_i == OFS_TOTAL) begin
      rd_mux = total_q; // R7
    end else if (avs_address_i == OFS_LOOPS) begin
      rd_mux = loops_q; // R8
    end else if (avs_address_i == OFS_CTRL) begin
      rd_mux = ctrl_rd;
    end else if (avs_address_i == OFS_IDLE) begin
      rd_mux = {12'h000, idle_q};
    end else if (avs_address_i == OFS_IGATE) begin
      rd_mux = igate_q;
    end else if (avs_address_i == OFS_MADDR) begin
      rd_mux = maddr_q;
    end else if (avs_address_i == OFS_STATUS) begin
      rd_mux = status_rd;
    end else if (avs_address_i == OFS_IRQ_STAT) begin
      rd_mux = {29'h0000_0000, irq_stat_q};
    end else if (avs_address_i == OFS_IRQ_EN) begin
      rd_mux = {29'h0000_0000, irq_en_q};
    end else if (avs_address_i == OFS_COUNT) begin
      rd_mux = out_cnt_q;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // one wait cycle per access, then the answer
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !(acc && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // configuration registers
  wire [31:0] idle_wr = merge({12'h000, idle_q}, avs_writedata_i, be_mask);
  wire [31:0] en_wr = merge({29'h0, irq_en_q}, avs_writedata_i, be_mask);
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RST;
      total_q <= TOTAL_RST;
      loops_q <= LOOPS_RST;
      gsrc_q <= 1'b0;
      ch_code_q <= 2'h0;
      idle_q <= {NCH{IDLE_LEVEL_ZERO}};
      igate_q <= IGATE_RST;
      irq_en_q <= '0;
    end else begin
      if (wr_mode) mode_q <= merge(mode_q, avs_writedata_i, be_mask);
      if (wr_total) total_q <= merge(total_q, avs_writedata_i, be_mask); // R7
      if (wr_loops) loops_q <= merge(loops_q, avs_writedata_i, be_mask); // R8
      if (wr_idle) idle_q <= idle_wr[NCH*IDLE_W-1:0];
      if (wr_igate) igate_q <= merge(igate_q, avs_writedata_i, be_mask);
      if (wr_en) irq_en_q <= en_wr[NIRQ-1:0];
      if (wr_ctrl && avs_byteenable_i[0]) gsrc_q <= avs_writedata_i[CTRL_GSRC_BIT];
      if (wr_ctrl && avs_byteenable_i[1]) begin
        ch_code_q <= avs_writedata_i[CTRL_CH_LSB +: 2];
      end
    end
  end

  // ==========================================================================
  // sample memory, two bytes per sample
  wire [31:0] next_maddr = maddr_q + SAMPLE_BYTES; // R13

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      maddr_q <= 32'h0000_0000;
    end else if (wr_maddr) begin
      maddr_q <= merge(maddr_q, avs_writedata_i, be_mask);
    end else if (wr_mdata) begin
      maddr_q <= next_maddr;
    end
  end

  // data storage only, so no reset needed
  always_ff @(posedge core_clk_i) begin
    if (wr_mdata) mem[maddr_q[MEM_AW:1]] <= avs_writedata_i[SW-1:0]; // R13
  end

  // ==========================================================================
  // gate source and idle levels
  logic gate_nx;
  logic gate_q;
  logic [NCH*SW-1:0] idle_lvl;

  grs_gate_sel u_gate (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .gate_ext_i(gate_ext_i),
    .src_int_i(gsrc_q),
    .run_i(state != GRS_IDLE),
    .period_i(igate_q[15:0]),
    .width_i(igate_q[31:16]),
    .gate_nx_o(gate_nx),
    .gate_o(gate_q)
  );

  grs_idle_level u_idle (
    .code_i(idle_q),
    .last_i(last_q),
    .level_o(idle_lvl)
  );

  // ==========================================================================
  // replay control
  wire mode_std = (mode_q == STANDARD_GATED_CODE); // R6
  wire mode_fifo = (mode_q == STREAMING_GATED_CODE); // R9
  wire play = (state == GRS_PLAY);
  wire fire = play && (std_q || stream_valid_i);
  wire underrun = play && !std_q && !stream_valid_i; // R10
  wire gate_end = play && !gate_nx;
  wire [31:0] rd_byte = pos_q << 1; // R13
  wire [SW-1:0] sample = std_q ? mem[rd_byte[MEM_AW:1]] : stream_data_i;
  wire last_of_image = (pos_q == total_q - 32'h0000_0001);
  wire [31:0] next_gates = gates_q + 32'h0000_0001;
  wire once_done = std_q && (loops_q == LOOPS_ONCE) && fire && last_of_image; // R3
  wire gate_limit = std_q ? (loops_q > LOOPS_ONCE) : (loops_q != LOOPS_INFINITE);
  wire gates_done = gate_end && gate_limit && (next_gates == loops_q); // R5 R11
  wire finish = sw_stop || once_done || underrun || gates_done;
  wire [1:0] ch_last = (ch_code_q == 2'h0) ? 2'h0 : (ch_code_q == 2'h1) ? 2'h1 : 2'h3;
  wire [NIRQ-1:0] events = {gate_nx && !gate_q && state != GRS_IDLE, underrun,
                            state != GRS_IDLE && next_state == GRS_IDLE};

  always_comb begin
    next_state = state;
    case (state)
      GRS_IDLE: begin
        if (sw_start && (mode_std || mode_fifo)) begin
          next_state = gate_nx ? GRS_PLAY : GRS_PAUSE;
        end
      end
      GRS_PAUSE: begin
        if (sw_stop) begin
          next_state = GRS_IDLE;
        end else if (gate_nx) begin
          next_state = GRS_PLAY; // R2
        end
      end
      GRS_PLAY: begin
        if (finish) begin
          next_state = GRS_IDLE; // R3 R10
        end else if (!gate_nx) begin
          next_state = GRS_PAUSE; // R1
        end
      end
      default: next_state = GRS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= GRS_IDLE;
      std_q <= 1'b0;
      stream_ready_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      state <= next_state;
      if (state == GRS_IDLE && sw_start) std_q <= mode_std;
      // ready only while the gate is open in stream mode
      stream_ready_o <= (next_state == GRS_PLAY) && !(state == GRS_IDLE ? mode_std : std_q);
      running_o <= (next_state != GRS_IDLE);
    end
  end

  // position is kept across pauses so the next gate continues
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 32'h0000_0000;
      gates_q <= 32'h0000_0000;
      out_cnt_q <= 32'h0000_0000;
      ch_idx_q <= 2'h0;
    end else if (state == GRS_IDLE && sw_start) begin
      pos_q <= 32'h0000_0000;
      gates_q <= 32'h0000_0000;
      out_cnt_q <= 32'h0000_0000;
      ch_idx_q <= 2'h0;
    end else begin
      if (fire && std_q) pos_q <= last_of_image ? 32'h0000_0000 : pos_q + 32'h0000_0001; // R4 R18
      if (fire) out_cnt_q <= out_cnt_q + 32'h0000_0001;
      if (fire) ch_idx_q <= (ch_idx_q == ch_last) ? 2'h0 : ch_idx_q + 2'h1;
      if (gate_end) gates_q <= next_gates; // R5 R11
    end
  end

  // ==========================================================================
  // converter outputs
  for (genvar c = 0; c < NCH; c++) begin : g_dac
    wire active = (2'(c) <= ch_last);
    wire hit = fire && (ch_idx_q == 2'(c));
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        dac_data_o[c*SW +: SW] <= DAC_ZERO;
        last_q[c*SW +: SW] <= DAC_ZERO;
      end else if (play && active) begin
        if (hit) begin
          dac_data_o[c*SW +: SW] <= sample; // R1
          last_q[c*SW +: SW] <= sample;
        end
      end else begin
        dac_data_o[c*SW +: SW] <= idle_lvl[c*SW +: SW]; // R16
      end
    end
  end

  // ==========================================================================
  // interrupts: set wins over a clear in the same cycle
  wire [NIRQ-1:0] clr_bits = wr_clr ? (avs_writedata_i[NIRQ-1:0] & be_mask[NIRQ-1:0]) : '0;
  wire [NIRQ-1:0] next_irq_stat = (irq_stat_q & ~clr_bits) | events;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= next_irq_stat;
      irq_o <= |(next_irq_stat & irq_en_q);
    end
  end

endmodule // grs_top

//--- verif/grs_asserts.sv
// Purpose: port-level checks of the gated replay sequencer
// Assumes: sees only the ports of grs_top, one clock domain
// Notes: bound from the bench top file
module grs_asserts
  import grs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic stream_valid_i,
  input wire logic stream_ready_o,
  input wire logic [NCH*SW-1:0] dac_data_o,
  input wire logic running_o,
  input wire logic irq_o
);
  // ========
  // bus answer
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  chk_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("wait low, no request");
  chk_rdata_holds: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i)
    else $error("read data moved");
  // ========
  // replay
  chk_ready_in_run: assert property (stream_ready_o |-> running_o || $past(running_o))
    else $error("ready while idle");
  chk_underrun_end: assert property (
    running_o && stream_ready_o && !stream_valid_i |-> ##[1:3] !running_o)
    else $error("underrun kept running");
  chk_idle_dac_hold: assert property (
    !running_o && !$past(running_o) && !$past(running_o, 2) && !$past(avs_write_i)
      && !$past(avs_write_i, 2) |-> $stable(dac_data_o))
    else $error("outputs moved while idle");
  // ========
  // interrupt
  chk_irq_rise: assert property (
    $rose(irq_o) |-> $past(running_o) || $past(running_o, 2) || $past(avs_write_i))
    else $error("irq rose, no event");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(avs_write_i))
    else $error("irq fell, no write");
  cov_underrun: cover property (running_o && stream_ready_o && !stream_valid_i);
  cov_irq: cover property ($rose(irq_o));
  cov_end: cover property ($fell(running_o));
endmodule // grs_asserts

//--- verif/grs_host_model.sv
// Purpose: host stream source feeding the sequencer
// Assumes: a word is taken at an edge with ready and valid high
// Notes: feed_i low starves the device
module grs_host_model
  import grs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic feed_i,
  input wire logic [SW-1:0] base_i,
  input wire logic stream_ready_i,
  output logic [SW-1:0] stream_data_o,
  output logic stream_valid_o,
  output logic [15:0] taken_o
);
  logic [SW-1:0] next_word;
  assign next_word = base_i + taken_o;
  assign stream_valid_o = feed_i;
  // released line shows the inverse
  assign stream_data_o = feed_i ? next_word : ~next_word;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taken_o <= 16'h0000;
    end else if (stream_ready_i && stream_valid_o) begin
      taken_o <= taken_o + 16'h0001;
    end
  end
endmodule // grs_host_model

//--- verif/test_gated_replay_sequencer.sv
// Purpose: self-checking bench for the gated replay sequencer
// Assumes: host stream model on the far side
// Notes: outputs sampled at the falling edge
module test_gated_replay_sequencer
  import grs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [AW-1:0] a;
    logic [DW-1:0] w;
    logic [DW-1:0] e;
  } grs_row_s;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [AW-1:0] avs_address_i = 16'h0000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DW-1:0] avs_writedata_i = 32'h0000_0000;
  logic [DW-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic gate_ext_i = 1'b0;
  logic [SW-1:0] stream_data_i;
  logic stream_valid_i;
  logic stream_ready_o;
  logic [NCH*SW-1:0] dac_data_o;
  logic running_o;
  logic irq_o;
  logic feed = 1'b1;
  logic [15:0] taken;
  logic [SW-1:0] ch0_s = 16'h0000;
  logic run_s;
  logic irq_s;
  logic [SW-1:0] q[$];
  logic [DW-1:0] rv;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int t0;
  // ========
  grs_row_s rows[7] = '{
    '{OFS_MODE, STANDARD_GATED_CODE, STANDARD_GATED_CODE},
    '{OFS_MODE, STREAMING_GATED_CODE, STREAMING_GATED_CODE},
    '{OFS_TOTAL, 32'h0000_0010, 32'h0000_0010},
    '{OFS_LOOPS, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
    '{OFS_LOOPS, 32'h0000_0002, 32'h0000_0002},
    '{16'h3FFC, 32'h1234_5678, 32'h0000_0000},
    '{OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0000}};
  logic [IDLE_W-1:0] lvl[4] = '{IDLE_LEVEL_HOLD_PREVIOUS, IDLE_LEVEL_NEGATIVE,
    IDLE_LEVEL_POSITIVE, IDLE_LEVEL_ZERO};
  logic [SW-1:0] lvx[4] = '{16'h1007, DAC_MOST_NEG, DAC_MOST_POS, DAC_ZERO};

  grs_top grs_top_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .gate_ext_i(gate_ext_i),
    .stream_data_i(stream_data_i), .stream_valid_i(stream_valid_i),
    .stream_ready_o(stream_ready_o), .dac_data_o(dac_data_o), .running_o(running_o),
    .irq_o(irq_o));
  grs_host_model grs_host_model_i (.core_clk_i(core_clk_i), .rst_n_i(nrst_i), .feed_i(feed),
    .base_i(16'h2000), .stream_ready_i(stream_ready_o), .stream_data_o(stream_data_i),
    .stream_valid_o(stream_valid_i), .taken_o(taken));

  always #4 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) begin
    if (dac_data_o[SW-1:0] !== ch0_s && dac_data_o[SW-1:0] !== DAC_ZERO) begin
      q.push_back(dac_data_o[SW-1:0]);
    end
    ch0_s = dac_data_o[SW-1:0];
    run_s = running_o;
    irq_s = irq_o;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
    end
  end

  // ========
  // tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_seq(input logic [SW-1:0] b, input int m);
    foreach (q[i]) begin
      chk_word(DW'(q[i]), DW'(b + SW'(m > 0 ? i % m : i)));
    end
  endtask
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      output logic [DW-1:0] r);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic pulse(input int h, input int l);
    gate_ext_i <= 1'b1;
    cyc(h);
    gate_ext_i <= 1'b0;
    cyc(l);
  endtask
  task automatic run(input logic [DW-1:0] mode, input logic [DW-1:0] loops,
                     input logic [DW-1:0] ctrl);
    wr(OFS_MODE, mode);
    wr(OFS_LOOPS, loops);
    q.delete();
    wr(OFS_CTRL, ctrl);
  endtask
  task automatic done(input string n);
    $display("test %s finished at %0t", n, $time);
  endtask

  // ========
  // sequence
  initial begin
    cyc(12);
    nrst_i <= 1'b1;
    cyc(3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rv);
      chk_word(rv, rows[i].e);
    end
    done("registers");
    wr(OFS_MADDR, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wr(OFS_MDATA, 32'h0000_1000 + DW'(i));
    rd(OFS_MADDR, rv);
    chk_word(rv, 8 * SAMPLE_BYTES);
    wr(OFS_TOTAL, 32'h0000_0008);
    wr(OFS_IRQ_EN, 32'h0000_0001);
    gate_ext_i <= 1'b1;
    run(STANDARD_GATED_CODE, LOOPS_ONCE, 32'h0000_0001);
    cyc(3);
    gate_ext_i <= 1'b0;
    cyc(6);
    chk_bit(run_s, 1'b1);
    chk_word(DW'(ch0_s), DW'(DAC_ZERO));
    t0 = q.size();
    cyc(4);
    chk_word(DW'(q.size()), DW'(t0));
    gate_ext_i <= 1'b1;
    cyc(30);
    chk_bit(run_s, 1'b0);
    chk_word(DW'(q.size()), 32'h0000_0008);
    chk_seq(16'h1000, 8);
    chk_bit(irq_s, 1'b1);
    wr(OFS_IRQ_CLR, 32'h0000_0007);
    cyc(1);
    chk_bit(irq_s, 1'b0);
    foreach (lvl[i]) begin
      wr(OFS_IDLE, DW'(lvl[i]));
      cyc(3);
      chk_word(DW'(ch0_s), DW'(lvx[i]));
    end
    done("standard single");
    gate_ext_i <= 1'b0;
    wr(OFS_IRQ_EN, 32'h0000_0000);
    run(STANDARD_GATED_CODE, 32'h0000_0003, 32'h0000_0001);
    repeat (3) pulse(5, 5);
    chk_bit(run_s, 1'b0);
    t0 = q.size();
    pulse(5, 5);
    chk_word(DW'(q.size()), DW'(t0));
    chk_seq(16'h1000, 8);
    chk_bit(irq_s, 1'b0);
    rd(OFS_IRQ_STAT, rv);
    chk_bit(rv[IRQ_DONE], 1'b1);
    wr(OFS_IRQ_CLR, 32'h0000_0007);
    done("standard counted");
    gate_ext_i <= 1'b1;
    run(STANDARD_GATED_CODE, LOOPS_INFINITE, 32'h0000_0001);
    cyc(24);
    chk_bit(run_s, 1'b1);
    chk_bit(q.size() >= 22, 1'b1);
    chk_seq(16'h1000, 8);
    wr(OFS_CTRL, 32'h0000_0002);
    cyc(3);
    chk_bit(run_s, 1'b0);
    gate_ext_i <= 1'b0;
    run(STANDARD_GATED_CODE, LOOPS_INFINITE, 32'h0000_0011);
    cyc(40);
    chk_bit(q.size() > 0, 1'b1);
    wr(OFS_CTRL, 32'h0000_0002);
    done("standard endless");
    t0 = taken;
    run(STREAMING_GATED_CODE, 32'h0000_0002, 32'h0000_0001);
    repeat (2) pulse(6, 5);
    chk_bit(run_s, 1'b0);
    chk_word(DW'(q.size()), DW'(taken) - DW'(t0));
    chk_seq(SW'(16'h2000 + t0), 0);
    wr(OFS_IRQ_EN, 32'h0000_0002);
    gate_ext_i <= 1'b1;
    run(STREAMING_GATED_CODE, LOOPS_INFINITE, 32'h0000_0001);
    cyc(6);
    chk_bit(run_s, 1'b1);
    feed <= 1'b0;
    cyc(4);
    chk_bit(run_s, 1'b0);
    chk_bit(irq_s, 1'b1);
    wr(OFS_IRQ_CLR, 32'h0000_0007);
    feed <= 1'b1;
    done("stream");
    run(STANDARD_GATED_CODE, LOOPS_INFINITE, 32'h0000_0001);
    cyc(4);
    nrst_i <= 1'b0;
    cyc(2);
    nrst_i <= 1'b1;
    cyc(3);
    chk_bit(run_s, 1'b0);
    rd(OFS_MODE, rv);
    chk_word(rv, MODE_RST);
    rd(OFS_TOTAL, rv);
    chk_word(rv, TOTAL_RST);
    rd(OFS_LOOPS, rv);
    chk_word(rv, LOOPS_RST);
    done("reset");
    stop_test();
  end
endmodule // test_gated_replay_sequencer

bind grs_top grs_asserts grs_asserts_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .stream_valid_i(stream_valid_i),
  .stream_ready_o(stream_ready_o), .dac_data_o(dac_data_o), .running_o(running_o),
  .irq_o(irq_o));
